// File: pkg/rss_defs.svh
`ifndef RSS_DEFS_SVH
`define RSS_DEFS_SVH
// Summary of operation
// - Full redundancy is offered only for two capable modules in the first two slots of a capable rack, otherwise the pair runs degraded.
// - In a main rack with a controller the pair monitors and saves supply data, manages redundancy and offers status to the application.
// - In an extension rack the pair monitors, saves and manages redundancy but offers no status to the application.
// - A module alone only monitors and saves its supply data, with no redundancy management and no application data.
// - Each module holds exactly one role, and only the master supplies both backplane rails.
// - After the first power-up the module in the left-most slot becomes master and the other one slave.
// - A slave that has taken over keeps the master role even when the other module is replaced.
// - When the master stops supplying, the other module takes over without a gap in rack power.
// - The redundancy-lost line goes low when any rail, presence or current capability of either module is bad.
// - A module checks both of its own rails before it supplies the backplane and flags lost redundancy otherwise.
// - The redundancy-lost line is active low, shows the pair status and is read only by the rack controller.
// - A self-test checks that the module is slave and flashes the master and redundancy indicators while it runs.
// - The reset button never switches off the power converter.
// - The alarm relay closes only with both rails good, controller alarm high or no controller, and the button released.
// - The master indicator is lit only while master with the button released, and it flashes during self-test instead.

// ==========================================
// Timing
`define RSS_CLK_PERIOD_NS 5
`define RSS_DEBOUNCE_NS 1000000
`define RSS_DEBOUNCE_CYCLES (`RSS_DEBOUNCE_NS / `RSS_CLK_PERIOD_NS)
`define RSS_DEB_CNT_W 18
`define RSS_FLASH_HALF_NS 250000000
`define RSS_FLASH_CYCLES (`RSS_FLASH_HALF_NS / `RSS_CLK_PERIOD_NS)
`define RSS_FLASH_CNT_W 26

// ==========================================
// Saved supply status word
`define RSS_ST_W 8
`define RSS_ST_OWN_HI 0
`define RSS_ST_OWN_LO 1
`define RSS_ST_OWN_CUR 2
`define RSS_ST_PAR_PRES 3
`define RSS_ST_PAR_HI 4
`define RSS_ST_PAR_LO 5
`define RSS_ST_PAR_CUR 6
`define RSS_ST_MASTER 7
`define RSS_ST_RST 8'h00
`endif

// File: pkg/rss_pkg.sv
package rss_pkg;
	// ==========================================
	// Role of this module in the pair
	typedef enum logic [1:0] {
		RSS_ROLE_INIT = 2'b00,
		RSS_ROLE_SLAVE = 2'b01,
		RSS_ROLE_MASTER = 2'b10,
		RSS_ROLE_TEST = 2'b11
	} rss_role_e;
endpackage : rss_pkg

// File: hdl/rss_debounce.sv
`timescale 1ns/1ps
module rss_debounce #(
	parameter int CYCLES = 200000,
	parameter logic RST_VAL = 1'b0
) (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	// Pin and clean level
	input wire logic raw_in,
	output logic clean_out
);
	logic sync1_reg, sync2_reg, clean_reg, clean_next;
	logic [17:0] cnt_reg, cnt_next;

	// ==========================================
	// Filter
	// A level must hold for the full count; short glitches restart it.
	always_comb begin
		clean_next = clean_reg;
		cnt_next = 18'h00000;
		if (sync2_reg != clean_reg) begin
			if (cnt_reg >= 18'(CYCLES - 1)) begin
				clean_next = sync2_reg;
			end else begin
				cnt_next = cnt_reg + 18'h00001;
			end
		end
	end

	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			sync1_reg <= RST_VAL;
			sync2_reg <= RST_VAL;
			clean_reg <= RST_VAL;
			cnt_reg <= 18'h00000;
		end else begin
			sync1_reg <= raw_in;
			sync2_reg <= sync1_reg;
			clean_reg <= clean_next;
			cnt_reg <= cnt_next;
		end
	end

	assign clean_out = clean_reg;
endmodule : rss_debounce

// File: hdl/rss_flasher.sv
`timescale 1ns/1ps
module rss_flasher #(
	parameter int CYCLES = 50000000
) (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	// Control and square wave
	input wire logic enable_in,
	output logic flash_out
);
	logic flash_reg, flash_next;
	logic [25:0] cnt_reg, cnt_next;

	// ==========================================
	// Half-period toggle
	always_comb begin
		flash_next = flash_reg;
		cnt_next = cnt_reg;
		if (!enable_in) begin
			flash_next = 1'b0;
			cnt_next = 26'h0000000;
		end else if (cnt_reg >= 26'(CYCLES - 1)) begin
			flash_next = !flash_reg;
			cnt_next = 26'h0000000;
		end else begin
			cnt_next = cnt_reg + 26'h0000001;
		end
	end

	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			flash_reg <= 1'b0;
			cnt_reg <= 26'h0000000;
		end else begin
			flash_reg <= flash_next;
			cnt_reg <= cnt_next;
		end
	end

	assign flash_out = flash_reg;
endmodule : rss_flasher

// File: hdl/rss_supervisor.sv
`timescale 1ns/1ps
`include "rss_defs.svh"
module rss_supervisor #(
	parameter int DEBOUNCE_CYCLES = `RSS_DEBOUNCE_CYCLES,
	parameter int FLASH_CYCLES = `RSS_FLASH_CYCLES
) (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	// Rack placement
	input wire logic left_slot_in,
	input wire logic first_slots_in,
	input wire logic rack_capable_in,
	input wire logic ctrl_present_in,
	input wire logic partner_present_in,
	// Own supply sense
	input wire logic own_high_rail_ok_in,
	input wire logic own_logic_rail_ok_in,
	input wire logic own_current_ok_in,
	// Partner supply sense
	input wire logic partner_high_rail_ok_in,
	input wire logic partner_logic_rail_ok_in,
	input wire logic partner_current_ok_in,
	input wire logic partner_supplying_in,
	// Controller and front panel
	input wire logic ctrl_alarm_n_in,
	input wire logic reset_button_in,
	input wire logic selftest_req_in,
	// Power control and role
	output logic converter_on_out,
	output logic supply_enable_out,
	output logic master_out,
	// Redundancy status
	output logic redundancy_lost_n_out,
	output logic full_redundancy_out,
	output logic manage_out,
	// Saved and application status
	output logic [`RSS_ST_W-1:0] saved_status_out,
	output logic [`RSS_ST_W-1:0] app_status_out,
	output logic app_status_valid_out,
	// Relay and indicators
	output logic alarm_relay_close_out,
	output logic active_led_out,
	output logic redund_led_out
);
	logic d_left, d_slots, d_cap, d_ctrl, d_par;
	logic d_hi, d_lo, d_cur, d_phi, d_plo, d_pcur, d_psup;
	logic d_alarm_n, d_button, d_test, flash;
	rss_pkg::rss_role_e role_reg, role_next;
	logic [17:0] settle_reg, settle_next;
	logic conv_reg, supply_reg, master_reg, lost_n_reg, full_reg, manage_reg;
	logic conv_next, supply_next, master_next, lost_n_next, full_next, manage_next;
	logic [`RSS_ST_W-1:0] saved_reg, saved_next, app_reg, app_next;
	logic app_valid_reg, app_valid_next, relay_reg, relay_next;
	logic act_led_reg, act_led_next, rd_led_reg, rd_led_next;
	logic own_ok, own_bad, par_bad, settled;

	// ==========================================
	// Input conditioning
	rss_debounce #(.CYCLES(DEBOUNCE_CYCLES), .RST_VAL(1'b0)) u_deb_left (
		.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
		.raw_in(left_slot_in), .clean_out(d_left)
	);
	rss_debounce #(.CYCLES(DEBOUNCE_CYCLES), .RST_VAL(1'b0)) u_deb_slots (
		.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
		.raw_in(first_slots_in), .clean_out(d_slots)
	);
	rss_debounce #(.CYCLES(DEBOUNCE_CYCLES), .RST_VAL(1'b0)) u_deb_cap (
		.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
		.raw_in(rack_capable_in), .clean_out(d_cap)
	);
	rss_debounce #(.CYCLES(DEBOUNCE_CYCLES), .RST_VAL(1'b0)) u_deb_ctrl (
		.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
		.raw_in(ctrl_present_in), .clean_out(d_ctrl)
	);
	rss_debounce #(.CYCLES(DEBOUNCE_CYCLES), .RST_VAL(1'b0)) u_deb_par (
		.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
		.raw_in(partner_present_in), .clean_out(d_par)
	);
	rss_debounce #(.CYCLES(DEBOUNCE_CYCLES), .RST_VAL(1'b0)) u_deb_hi (
		.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
		.raw_in(own_high_rail_ok_in), .clean_out(d_hi)
	);
	rss_debounce #(.CYCLES(DEBOUNCE_CYCLES), .RST_VAL(1'b0)) u_deb_lo (
		.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
		.raw_in(own_logic_rail_ok_in), .clean_out(d_lo)
	);
	rss_debounce #(.CYCLES(DEBOUNCE_CYCLES), .RST_VAL(1'b0)) u_deb_cur (
		.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
		.raw_in(own_current_ok_in), .clean_out(d_cur)
	);
	rss_debounce #(.CYCLES(DEBOUNCE_CYCLES), .RST_VAL(1'b0)) u_deb_phi (
		.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
		.raw_in(partner_high_rail_ok_in), .clean_out(d_phi)
	);
	rss_debounce #(.CYCLES(DEBOUNCE_CYCLES), .RST_VAL(1'b0)) u_deb_plo (
		.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
		.raw_in(partner_logic_rail_ok_in), .clean_out(d_plo)
	);
	rss_debounce #(.CYCLES(DEBOUNCE_CYCLES), .RST_VAL(1'b0)) u_deb_pcur (
		.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
		.raw_in(partner_current_ok_in), .clean_out(d_pcur)
	);
	rss_debounce #(.CYCLES(DEBOUNCE_CYCLES), .RST_VAL(1'b0)) u_deb_psup (
		.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
		.raw_in(partner_supplying_in), .clean_out(d_psup)
	);
	rss_debounce #(.CYCLES(DEBOUNCE_CYCLES), .RST_VAL(1'b0)) u_deb_alarm (
		.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
		.raw_in(ctrl_alarm_n_in), .clean_out(d_alarm_n)
	);
	// Button filter rests pressed so the relay and indicator stay safe until it settles.
	rss_debounce #(.CYCLES(DEBOUNCE_CYCLES), .RST_VAL(1'b1)) u_deb_button (
		.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
		.raw_in(reset_button_in), .clean_out(d_button)
	);
	rss_debounce #(.CYCLES(DEBOUNCE_CYCLES), .RST_VAL(1'b0)) u_deb_test (
		.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
		.raw_in(selftest_req_in), .clean_out(d_test)
	);

	rss_flasher #(.CYCLES(FLASH_CYCLES)) u_flash (
		.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
		.enable_in(role_reg == rss_pkg::RSS_ROLE_TEST), .flash_out(flash)
	);

	// ==========================================
	// Role selection
	assign own_ok = d_hi && d_lo;
	assign own_bad = !d_hi || !d_lo || !d_cur;
	assign par_bad = !d_par || !d_phi || !d_plo || !d_pcur;
	assign settled = (settle_reg >= 18'(DEBOUNCE_CYCLES + 3));

	always_comb begin
		role_next = role_reg;
		settle_next = settled ? settle_reg : settle_reg + 18'h00001;
		case (role_reg)
			rss_pkg::RSS_ROLE_INIT: begin
				// Wait until every filter has seen its pin before choosing.
				if (settled) begin
					if (d_left || !d_par) begin
						role_next = rss_pkg::RSS_ROLE_MASTER;
					end else begin
						role_next = rss_pkg::RSS_ROLE_SLAVE;
					end
				end
			end
			rss_pkg::RSS_ROLE_SLAVE: begin
				if (own_ok && (!d_par || !d_psup)) begin
					role_next = rss_pkg::RSS_ROLE_MASTER;
				end else if (d_test && manage_reg) begin
					role_next = rss_pkg::RSS_ROLE_TEST;
				end
			end
			rss_pkg::RSS_ROLE_MASTER: begin
				// Presence of the partner is not looked at, so a swap keeps this role.
				if (!own_ok) begin
					role_next = rss_pkg::RSS_ROLE_SLAVE;
				end
			end
			rss_pkg::RSS_ROLE_TEST: begin
				if (own_ok && (!d_par || !d_psup)) begin
					role_next = rss_pkg::RSS_ROLE_MASTER;
				end else if (!d_test) begin
					role_next = rss_pkg::RSS_ROLE_SLAVE;
				end
			end
			default: role_next = rss_pkg::RSS_ROLE_INIT;
		endcase
	end

	// ==========================================
	// Outputs
	always_comb begin
		conv_next = 1'b1;
		master_next = (role_next == rss_pkg::RSS_ROLE_MASTER);
		supply_next = master_next && own_ok;
		lost_n_next = !(own_bad || par_bad);
		full_next = d_cap && d_slots && d_par;
		manage_next = full_next;
		saved_next = saved_reg;
		// Each field goes to its defined place, so the word layout lives in one header only.
		if (settled) begin
			saved_next[`RSS_ST_OWN_HI] = d_hi;
			saved_next[`RSS_ST_OWN_LO] = d_lo;
			saved_next[`RSS_ST_OWN_CUR] = d_cur;
			saved_next[`RSS_ST_PAR_PRES] = d_par;
			saved_next[`RSS_ST_PAR_HI] = d_phi;
			saved_next[`RSS_ST_PAR_LO] = d_plo;
			saved_next[`RSS_ST_PAR_CUR] = d_pcur;
			saved_next[`RSS_ST_MASTER] = master_next;
		end
		app_valid_next = full_next && d_ctrl;
		app_next = app_valid_next ? saved_next : `RSS_ST_RST;
		relay_next = d_hi && d_lo && (d_alarm_n || !d_ctrl) && !d_button;
		if (role_next == rss_pkg::RSS_ROLE_TEST) begin
			act_led_next = flash;
			rd_led_next = flash;
		end else begin
			act_led_next = master_next && !d_button;
			rd_led_next = manage_next && lost_n_next;
		end
	end

	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			role_reg <= rss_pkg::RSS_ROLE_INIT;
			settle_reg <= 18'h00000;
			conv_reg <= 1'b1;
			supply_reg <= 1'b0;
			master_reg <= 1'b0;
			lost_n_reg <= 1'b0;
			full_reg <= 1'b0;
			manage_reg <= 1'b0;
			saved_reg <= `RSS_ST_RST;
			app_reg <= `RSS_ST_RST;
			app_valid_reg <= 1'b0;
			relay_reg <= 1'b0;
			act_led_reg <= 1'b0;
			rd_led_reg <= 1'b0;
		end else begin
			role_reg <= role_next;
			settle_reg <= settle_next;
			conv_reg <= conv_next;
			supply_reg <= supply_next;
			master_reg <= master_next;
			lost_n_reg <= lost_n_next;
			full_reg <= full_next;
			manage_reg <= manage_next;
			saved_reg <= saved_next;
			app_reg <= app_next;
			app_valid_reg <= app_valid_next;
			relay_reg <= relay_next;
			act_led_reg <= act_led_next;
			rd_led_reg <= rd_led_next;
		end
	end

	assign converter_on_out = conv_reg;
	assign supply_enable_out = supply_reg;
	assign master_out = master_reg;
	assign redundancy_lost_n_out = lost_n_reg;
	assign full_redundancy_out = full_reg;
	assign manage_out = manage_reg;
	assign saved_status_out = saved_reg;
	assign app_status_out = app_reg;
	assign app_status_valid_out = app_valid_reg;
	assign alarm_relay_close_out = relay_reg;
	assign active_led_out = act_led_reg;
	assign redund_led_out = rd_led_reg;

	// ==========================================
	// Checks
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (sys_rst_in);
	// Every output is registered, so most checks look one cycle after their cause.

	conv_on_a: assert property (converter_on_out)
		else $error("converter switched off");
	supply_rails_a: assert property (supply_enable_out |-> master_out && $past(own_ok))
		else $error("supply without good rails");
	lost_partner_a: assert property (!d_par |=> !redundancy_lost_n_out)
		else $error("lost line high without partner");
	lost_clear_a: assert property (!own_bad && !par_bad |=> redundancy_lost_n_out)
		else $error("lost line low with pair healthy");
	relay_btn_a: assert property (d_button |=> !alarm_relay_close_out)
		else $error("relay closed with button pressed");
	relay_alarm_a: assert property (d_ctrl && !d_alarm_n |=> !alarm_relay_close_out)
		else $error("relay closed with controller alarm");
	led_btn_a: assert property (d_button && role_next != rss_pkg::RSS_ROLE_TEST
		|=> !active_led_out)
		else $error("master indicator lit with button");
	keep_master_a: assert property (role_reg == rss_pkg::RSS_ROLE_MASTER && own_ok
		|=> role_reg == rss_pkg::RSS_ROLE_MASTER)
		else $error("master role dropped");
	takeover_a: assert property (role_reg == rss_pkg::RSS_ROLE_SLAVE && own_ok
		&& !d_psup |=> master_out)
		else $error("no takeover");
	init_role_a: assert property (role_reg == rss_pkg::RSS_ROLE_INIT && settled
		&& d_par && !d_left |=> role_reg == rss_pkg::RSS_ROLE_SLAVE)
		else $error("right slot took master");
	single_a: assert property (!d_par |=> !manage_out && !app_status_valid_out)
		else $error("lone module manages pair");
	ext_rack_a: assert property (!d_ctrl |=> !app_status_valid_out)
		else $error("status offered in extension rack");
	test_flash_a: assert property (role_next == rss_pkg::RSS_ROLE_TEST |=>
		active_led_out == $past(flash) && redund_led_out == $past(flash))
		else $error("indicators not flashing in self-test");
	test_slave_a: assert property (role_next == rss_pkg::RSS_ROLE_TEST
		&& role_reg != rss_pkg::RSS_ROLE_TEST |-> role_reg == rss_pkg::RSS_ROLE_SLAVE)
		else $error("self-test entered outside slave role");
	hold_slave_a: assert property (role_reg == rss_pkg::RSS_ROLE_SLAVE && d_par
		&& d_psup |=> !master_out)
		else $error("second master while partner supplies");
	relay_rail_a: assert property (!d_hi || !d_lo |=> !alarm_relay_close_out)
		else $error("relay closed with a bad rail");
	full_need_a: assert property (!d_cap || !d_slots |=> !full_redundancy_out)
		else $error("full redundancy in wrong placement");
	lost_own_a: assert property (own_bad |=> !redundancy_lost_n_out)
		else $error("lost line high with own supply bad");

	takeover_c: cover property (role_reg == rss_pkg::RSS_ROLE_SLAVE
		##1 role_reg == rss_pkg::RSS_ROLE_MASTER);
	test_c: cover property (role_reg == rss_pkg::RSS_ROLE_TEST ##1 flash);
	relay_c: cover property (alarm_relay_close_out ##1 !alarm_relay_close_out);
	init_c: cover property (role_reg == rss_pkg::RSS_ROLE_INIT
		##1 role_reg == rss_pkg::RSS_ROLE_SLAVE);
	lone_c: cover property (role_reg == rss_pkg::RSS_ROLE_INIT && settled && !d_par
		##1 master_out);
endmodule : rss_supervisor

// File: verif/rss_ctrl_model.sv
`timescale 1ns/1ps
// ==========================================
// Rack controller model: drives the alarm line and reads the redundancy status line.
module rss_ctrl_model (
	// Clock
	input wire logic ref_clk_in,
	// Controller state
	input wire logic present_in,
	input wire logic running_in,
	input wire logic blocking_err_in,
	// Backplane lines
	input wire logic redundancy_lost_n_in,
	output logic ctrl_alarm_n_out,
	output logic redundancy_ok_out
);
	logic alarm_n_reg = 1'b0;
	logic ok_reg = 1'b0;
	always @(posedge ref_clk_in) begin
		if (present_in) begin
			alarm_n_reg <= running_in & ~blocking_err_in;
		end else begin
			// With no controller fitted the line floats, so it wanders every cycle.
			alarm_n_reg <= ~alarm_n_reg;
		end
		ok_reg <= redundancy_lost_n_in;
	end
	assign ctrl_alarm_n_out = alarm_n_reg;
	assign redundancy_ok_out = ok_reg;
endmodule : rss_ctrl_model

// File: verif/rss_supervisor_tb.sv
`timescale 1ns/1ps
// ==========================================
// Pin vector bits: 0 left, 1 first, 2 capable, 3 ctrl, 4 partner, 5-7 own hi/lo/cur,
// 8-10 partner hi/lo/cur, 11 partner supplying, 12 running, 13 button, 14 test, 15 error.
module rss_supervisor_tb;
	localparam int DEB = 4;
	localparam int SETTLE = DEB + 8;
	logic ref_clk_in;
	logic sys_rst_in = 1'b1;
	logic [15:0] pins = 16'h1ffe;
	logic [15:0] np;
	logic alarm_n;
	logic [31:0] seed = 32'h0a89c6bc;
	logic m_exp = 1'b0;
	logic [25:0] exp_q[$];
	wire [25:0] obs;
	wire ctrl_ok;
	int error_cnt = 0;
	int check_count = 0;
	event chk_ev;

	rss_ctrl_model ctrl (.ref_clk_in(ref_clk_in), .present_in(pins[3]), .running_in(pins[12]),
		.blocking_err_in(pins[15]), .redundancy_lost_n_in(obs[22]),
		.ctrl_alarm_n_out(alarm_n), .redundancy_ok_out(ctrl_ok));

	rss_supervisor #(.DEBOUNCE_CYCLES(DEB), .FLASH_CYCLES(3)) uut (
		.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
		.left_slot_in(pins[0]), .first_slots_in(pins[1]), .rack_capable_in(pins[2]),
		.ctrl_present_in(pins[3]), .partner_present_in(pins[4]),
		.own_high_rail_ok_in(pins[5]), .own_logic_rail_ok_in(pins[6]),
		.own_current_ok_in(pins[7]), .partner_high_rail_ok_in(pins[8]),
		.partner_logic_rail_ok_in(pins[9]), .partner_current_ok_in(pins[10]),
		.partner_supplying_in(pins[11]), .ctrl_alarm_n_in(alarm_n),
		.reset_button_in(pins[13]), .selftest_req_in(pins[14]),
		.converter_on_out(obs[25]), .supply_enable_out(obs[24]), .master_out(obs[23]),
		.redundancy_lost_n_out(obs[22]), .full_redundancy_out(obs[21]),
		.manage_out(obs[20]), .saved_status_out(obs[19:12]), .app_status_out(obs[11:4]),
		.app_status_valid_out(obs[3]), .alarm_relay_close_out(obs[2]),
		.active_led_out(obs[1]), .redund_led_out(obs[0]));

	initial begin
		ref_clk_in = 1'b0;
		forever #2.5 ref_clk_in = ~ref_clk_in;
	end

	// ==========================================
	// Reference model
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs

	// A master that loses its own rails steps down; a healthy slave takes over once the
	// partner stops supplying or is gone, since an absent module supplies nothing.
	function automatic logic next_role(input logic m, input logic [15:0] p);
		if (m && !(p[5] && p[6])) return 1'b0;
		if (!m && (!p[11] || !p[4]) && p[5] && p[6]) return 1'b1;
		return m;
	endfunction : next_role

	function automatic logic [25:0] expect_out(input logic [15:0] p, input logic m);
		logic ln;
		logic f;
		logic v;
		logic rl;
		logic [7:0] sv;
		ln = p[5] & p[6] & p[7] & p[4] & p[8] & p[9] & p[10];
		f = p[2] & p[1] & p[4];
		v = f & p[3];
		rl = p[5] & p[6] & ((p[12] & ~p[15]) | ~p[3]) & ~p[13];
		sv = {m, p[10], p[9], p[8], p[4], p[7], p[6], p[5]};
		return {1'b1, m & p[5] & p[6], m, ln, f, f, sv, v ? sv : 8'h00, v, rl, m & ~p[13], f & ln};
	endfunction : expect_out

	// ==========================================
	// Checks and drivers
	task automatic cmp_vec(input logic [25:0] got, input logic [25:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp_vec

	task automatic cmp_bit(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp_bit

	task automatic drive(input logic [15:0] p);
		@(posedge ref_clk_in);
		pins <= p;
	endtask : drive

	task automatic step(input logic [15:0] p);
		drive(p);
		m_exp = next_role(m_exp, p);
		exp_q.push_back(expect_out(p, m_exp));
		repeat (SETTLE) @(posedge ref_clk_in);
		-> chk_ev;
	endtask : step

	task automatic do_reset(input logic [15:0] p);
		drive(p);
		sys_rst_in <= 1'b1;
		repeat (16) @(posedge ref_clk_in);
		#1;
		cmp_bit(obs[25], 1'b1);
		cmp_bit(obs[22], 1'b0);
		@(posedge ref_clk_in);
		sys_rst_in <= 1'b0;
		m_exp = p[0] | ~p[4];
		step(p);
	endtask : do_reset

	task automatic report_and_stop();
		if (exp_q.size() > 0) error_cnt++;
		if (error_cnt == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : report_and_stop

	// The scoreboard samples a moment after the marking edge, once everything has landed.
	initial begin
		logic [25:0] exp_v;
		forever begin
			@(chk_ev);
			#1;
			if (exp_q.size() > 0) begin
				exp_v = exp_q.pop_front();
				cmp_vec(obs, exp_v);
				cmp_bit(ctrl_ok, exp_v[22]);
			end
		end
	end

	initial begin
		repeat (20000) @(posedge ref_clk_in);
		error_cnt++;
		report_and_stop();
	end

	// ==========================================
	// Scenarios
	initial begin
		int tog;
		int tog_rd;
		logic [1:0] prev;
		do_reset(16'h1fff);
		do_reset(16'h1ffe);
		step(16'h17fe);
		step(16'h1fee);
		drive(16'h3fee);
		@(posedge ref_clk_in);
		step(16'h1fee);
		step(16'h1ffe);
		step(16'h1fde);
		step(16'h1ffe);
		drive(16'h5ffe);
		repeat (SETTLE) @(posedge ref_clk_in);
		#1;
		tog = 0;
		tog_rd = 0;
		prev = obs[1:0];
		repeat (12) begin
			@(posedge ref_clk_in);
			#1;
			if (obs[1] !== prev[1]) tog++;
			if (obs[0] !== prev[0]) tog_rd++;
			prev = obs[1:0];
		end
		cmp_bit(tog >= 2, 1'b1);
		cmp_bit(tog_rd >= 2, 1'b1);
		cmp_bit(obs[23], 1'b0);
		step(16'h1ffe);
		repeat (40) begin
			seed = xs(seed);
			np = seed[15:0];
			np[5] = |seed[17:16];
			np[6] = |seed[19:18];
			np[14] = 1'b0;
			if (!(np[5] && np[6])) np[11] = 1'b1;
			step(np);
		end
		do_reset(16'h1fee);
		@(posedge ref_clk_in);
		report_and_stop();
	end
endmodule : rss_supervisor_tb
